/* File: core/line_frame_timing_alarm.sv */
// Line-side transmit timing, frame pulse and receive alarm logic
// ===========================================================================

`timescale 1ns/1ps
`default_nettype none
`include "line_timing_cfg.svh"

module line_frame_timing_alarm #(
	parameter int CHANNELS = `CHAN_COUNT
) (
	input  wire logic                    mclk,                // 100 MHz clock
	input  wire logic                    rst_n,               // Sync reset
	input  wire line_timing_pkg::chan_alarm_t [CHANNELS-1:0] alarm_in, // Alarms
	input  wire line_timing_pkg::chan_cfg_t [CHANNELS-1:0] chan_cfg, // Modes
	input  wire logic                    line_clock_output_enable, // Line clk
	input  wire logic                    line_clk_syn,        // Synth line clk
	input  wire logic [CHANNELS-1:0]     line_data_in,        // Tx serial data
	input  wire logic [CHANNELS-1:0]     recovered_byte_clock, // Per channel
	input  wire logic                    frame_position_in,   // Pin, async
	input  wire logic                    timing_source_select, // 1 ignores pin
	input  wire logic                    byte_clock_is_synth, // Pin carries syn
	input  wire logic [1:0]              pulse_channel_select, // Pulse source
	output logic [CHANNELS-1:0]          receive_alarm_out,   // Per channel
	output logic [CHANNELS-1:0]          transmit_line_clock, // Gated line clk
	output logic [CHANNELS-1:0]          transmit_line_data,  // Serial data
	output logic                         tx_byte_clock_out,   // Line clk / 8
	output logic                         frame_pulse_out,     // 8 kHz pulse
	output logic [CHANNELS-1:0]          chan_byte_clock,     // Tx timing
	output logic [CHANNELS-1:0]          chan_frame_start     // Tx frame start
);
	// =======================================================================
	// Input synchronisers: three stages, a change counts when 2 and 3 agree
	// Costs one cycle of latency, but a single metastable sample can
	// never turn into a false clock edge or a false marker
	logic [2:0] fpi_sync_q, fpi_sync_d;
	logic [2:0] lck_sync_q, lck_sync_d;
	logic [CHANNELS-1:0] rbc1_q, rbc2_q, rbc3_q;
	logic [CHANNELS-1:0] rbc1_d, rbc2_d, rbc3_d;
	logic fpi_level_q, fpi_level_d;
	logic lck_level_q, lck_level_d;
	logic [CHANNELS-1:0] rbc_level_q, rbc_level_d;
	always_comb
	begin
		fpi_sync_d = {fpi_sync_q[1:0], frame_position_in};
		lck_sync_d = {lck_sync_q[1:0], line_clk_syn};
		rbc1_d = recovered_byte_clock;
		rbc2_d = rbc1_q;
		rbc3_d = rbc2_q;
		fpi_level_d = (fpi_sync_q[1] == fpi_sync_q[2]) ? fpi_sync_q[2]
			: fpi_level_q;
		lck_level_d = (lck_sync_q[1] == lck_sync_q[2]) ? lck_sync_q[2]
			: lck_level_q;
		for (int i = 0; i < CHANNELS; i++)
			rbc_level_d[i] = (rbc2_q[i] == rbc3_q[i]) ? rbc3_q[i]
				: rbc_level_q[i];
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			fpi_sync_q  <= 3'h0;
			lck_sync_q  <= 3'h0;
			rbc1_q      <= '0;
			rbc2_q      <= '0;
			rbc3_q      <= '0;
			fpi_level_q <= 1'b0;
			lck_level_q <= 1'b0;
			rbc_level_q <= '0;
		end
		else
		begin
			fpi_sync_q  <= fpi_sync_d;
			lck_sync_q  <= lck_sync_d;
			rbc1_q      <= rbc1_d;
			rbc2_q      <= rbc2_d;
			rbc3_q      <= rbc3_d;
			fpi_level_q <= fpi_level_d;
			lck_level_q <= lck_level_d;
			rbc_level_q <= rbc_level_d;
		end
	end

	// =======================================================================
	// Line clock edges, byte clock divider and frame counter
	logic       lck_rise, lck_fall;
	logic [2:0] div_q, div_d;
	logic       bclk_q, bclk_d;
	logic       bclk_rise;
	logic [11:0] fcnt_q, fcnt_d;
	logic       fpi_take;
	logic       fp_q, fp_d;
	logic [CHANNELS-1:0] line_clk_q, line_clk_d;
	logic [CHANNELS-1:0] line_data_q, line_data_d;
	logic [CHANNELS-1:0] alarm_q, alarm_d;
	logic [CHANNELS-1:0] cbclk_q, cbclk_d;
	logic [CHANNELS-1:0] cfs_q, cfs_d;

	// Alarm reduction shared by every channel
	function automatic logic alarm_any(
		input line_timing_pkg::chan_alarm_t a
	);
		alarm_any = |(a.active & a.enable);
	endfunction : alarm_any

	assign lck_rise = lck_level_d & ~lck_level_q;
	assign lck_fall = ~lck_level_d & lck_level_q;
	// Divider edge: byte clock rises on line clock rise with count three
	// The divider starts at zero after reset, so the first byte clock
	// rise needs four line clock rises
	assign bclk_rise = lck_rise && (div_q == 3'h3);
	// Realignment is gated so a stale marker can never pull the shared
	// counter while the byte clock pin is not the synthesized clock
	// Pin sampled on byte clock rise, only when timing source is synth
	assign fpi_take = bclk_rise && !timing_source_select
		&& byte_clock_is_synth && fpi_level_q;

	always_comb
	begin
		div_d = div_q;
		bclk_d = bclk_q;
		if (lck_rise)
		begin
			div_d = div_q + 3'h1;
			bclk_d = (div_q == 3'h3) ? 1'b1
				: (div_q == 3'h7) ? 1'b0 : bclk_q;
		end
		// A taken marker wins over the natural wrap, so realignment
		// always lands on the same byte clock rise that sampled it
		fcnt_d = fcnt_q;
		fp_d = fp_q;
		if (bclk_rise)
		begin
			if (fpi_take)
				fcnt_d = 12'h000;
			else if (fcnt_q == `FRAME_LAST)
				fcnt_d = 12'h000;
			else
				fcnt_d = fcnt_q + 12'h001;
			fp_d = 1'b0;
		end
		cfs_d = '0;
		for (int i = 0; i < CHANNELS; i++)
		begin
			// Loop-timed channels use the recovered clock level instead
			cbclk_d[i] = chan_cfg[i].loop_timed ? rbc_level_q[i]
				: bclk_d;
			if (bclk_rise && fcnt_d == 12'h000 && chan_cfg[i].frame_align_en
				&& !chan_cfg[i].loop_timed)
				cfs_d[i] = 1'b1;
			line_clk_d[i] = line_clock_output_enable & lck_level_d;
			line_data_d[i] = lck_fall ? line_data_in[i]
				: line_data_q[i];
			alarm_d[i] = alarm_any(alarm_in[i]);
		end
		// Pulse taken from the chosen self-timed channel's frame start, or from counter zero if that channel is not loop timed, aligns not and is not in line loopback
		if (bclk_rise)
			fp_d = cfs_d[pulse_channel_select]
				|| (fcnt_d == 12'h000 && !chan_cfg[pulse_channel_select]
				.frame_align_en && !chan_cfg[pulse_channel_select]
				.loop_timed && !chan_cfg[pulse_channel_select]
				.line_loopback);
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			div_q       <= 3'h0;
			bclk_q      <= 1'b0;
			fcnt_q      <= 12'h000;
			fp_q        <= 1'b0;
			cbclk_q     <= '0;
			cfs_q       <= '0;
			line_clk_q  <= '0;
			line_data_q <= '0;
			alarm_q     <= '0;
		end
		else
		begin
			div_q       <= div_d;
			bclk_q      <= bclk_d;
			fcnt_q      <= fcnt_d;
			fp_q        <= fp_d;
			cbclk_q     <= cbclk_d;
			cfs_q       <= cfs_d;
			line_clk_q  <= line_clk_d;
			line_data_q <= line_data_d;
			alarm_q     <= alarm_d;
		end
	end

	// Every output comes straight from a register
	assign tx_byte_clock_out   = bclk_q;
	assign frame_pulse_out     = fp_q;
	assign chan_byte_clock     = cbclk_q;
	assign chan_frame_start    = cfs_q;
	assign transmit_line_clock = line_clk_q;
	assign transmit_line_data  = line_data_q;
	assign receive_alarm_out   = alarm_q;

	// =======================================================================
	// Checks
	a_counter_range: assert property (@(posedge mclk) disable iff (!rst_n)
		fcnt_q <= `FRAME_LAST) else $error("frame counter out of range");
	a_clock_gated: assert property (@(posedge mclk) disable iff (!rst_n)
		!line_clock_output_enable |=> transmit_line_clock == '0)
		else $error("line clock driven while disabled");
	a_alarm_follow: assert property (@(posedge mclk) disable iff (!rst_n)
		receive_alarm_out[0] == $past(alarm_any(alarm_in[0])))
		else $error("alarm output wrong");
	a_alarm_masked: assert property (@(posedge mclk) disable iff (!rst_n)
		(alarm_in[1].enable == 14'h0000) |=> !receive_alarm_out[1])
		else $error("disabled alarm reached output");
	a_data_fall: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(transmit_line_data) |-> $past(lck_fall))
		else $error("line data changed off falling edge");
	a_pulse_rise: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(frame_pulse_out) |-> $past(bclk_rise))
		else $error("frame pulse changed off byte clock rise");
	a_sel_ignores: assert property (@(posedge mclk) disable iff (!rst_n)
		timing_source_select |-> !fpi_take)
		else $error("position input used while ignored");
	a_align_restart: assert property (@(posedge mclk) disable iff (!rst_n)
		fpi_take |=> fcnt_q == 12'h000)
		else $error("counter not realigned");
	a_loop_noalign: assert property (@(posedge mclk) disable iff (!rst_n)
		chan_cfg[0].loop_timed |=> !chan_frame_start[0])
		else $error("loop-timed channel aligned");
	a_byte_half: assert property (@(posedge mclk) disable iff (!rst_n)
		bclk_rise |=> tx_byte_clock_out)
		else $error("byte clock did not rise");

	// =======================================================================
	// Frame counter and alignment checks
	a_align_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(fpi_take && chan_cfg[1].frame_align_en && !chan_cfg[1].loop_timed)
		|=> chan_frame_start[1]) else $error("aligned start missing");
	a_count_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
		(bclk_rise && !fpi_take && fcnt_q == `FRAME_LAST) |=> fcnt_q == 12'h000)
		else $error("frame counter did not wrap");
	a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
		(bclk_rise && !fpi_take && fcnt_q != `FRAME_LAST)
		|=> fcnt_q == $past(fcnt_q) + 12'h001) else $error("bad step");
	a_count_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!bclk_rise |=> $stable(fcnt_q))
		else $error("frame counter moved off byte clock rise");
	a_pulse_stands: assert property (@(posedge mclk) disable iff (!rst_n)
		(frame_pulse_out && !bclk_rise) |=> frame_pulse_out)
		else $error("frame pulse dropped early");
	a_start_single: assert property (@(posedge mclk) disable iff (!rst_n)
		chan_frame_start[1] |=> !chan_frame_start[1])
		else $error("frame start longer than one cycle");

	// =======================================================================
	// Channel timing and line side checks
	a_loop_clock: assert property (@(posedge mclk) disable iff (!rst_n)
		chan_cfg[0].loop_timed |=> chan_byte_clock[0] == $past(rbc_level_q[0]))
		else $error("loop clock not from recovered clock");
	a_self_clock: assert property (@(posedge mclk) disable iff (!rst_n)
		!chan_cfg[1].loop_timed |=> chan_byte_clock[1] == tx_byte_clock_out)
		else $error("self-timed clock not byte clock");
	a_pulse_loop: assert property (@(posedge mclk) disable iff (!rst_n)
		(bclk_rise && chan_cfg[pulse_channel_select].loop_timed)
		|=> !frame_pulse_out) else $error("pulse from loop channel");
	a_clock_follow: assert property (@(posedge mclk) disable iff (!rst_n)
		line_clock_output_enable |=> transmit_line_clock[1] == $past(lck_level_d))
		else $error("enabled line clock wrong");
	a_alarm_last: assert property (@(posedge mclk) disable iff (!rst_n)
		receive_alarm_out[3] == $past(alarm_any(alarm_in[3])))
		else $error("alarm output wrong on last channel");
	a_divider_fall: assert property (@(posedge mclk) disable iff (!rst_n)
		(lck_rise && div_q == 3'h7) |=> !tx_byte_clock_out)
		else $error("byte clock did not fall");

	// =======================================================================
	// Cover points
	c_pulse: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(frame_pulse_out));
	c_ignored: cover property (@(posedge mclk) disable iff (!rst_n)
		timing_source_select && bclk_rise && fpi_level_q);
	c_loop_clock: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(chan_byte_clock[0]));
	c_align: cover property (@(posedge mclk) disable iff (!rst_n) fpi_take);
	c_alarm: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(receive_alarm_out[0]));
endmodule : line_frame_timing_alarm
`default_nettype wire

/* File: core/line_timing_cfg.svh */
// Timing counts and sizes for the line frame timing and alarm block
`ifndef LINE_TIMING_CFG_SVH
`define LINE_TIMING_CFG_SVH
`define FRAME_CYCLES      12'd2430
`define FRAME_LAST        12'd2429
`define LINE_RATE_KHZ     155520
`define BYTE_CLK_DIV      8
`define ALARM_SRC_COUNT   14
`define CHAN_COUNT        4
`endif

/* File: core/line_timing_pkg.sv */
// Types shared by the line frame timing and alarm block
package line_timing_pkg;
	typedef struct packed {
		logic loop_timed;     // Channel transmit timed from recovered clock
		logic line_loopback;  // Channel in line loopback
		logic frame_align_en; // Channel follows the global frame counter
	} chan_cfg_t;
	typedef struct packed {
		logic [13:0] active;  // Detected alarm conditions, one bit each
		logic [13:0] enable;  // Per-source enables from both alarm controls
	} chan_alarm_t;
endpackage : line_timing_pkg

/* File: verif/line_side_partner.sv */
// Far-side model: optical module clocks and system frame marker source
`timescale 1ns/1ps
`default_nettype none
module line_side_partner (
	input  wire logic       mclk,              // Bench clock
	input  wire logic       fp_go,             // Request one marker pulse
	input  wire logic       byte_clk,          // Device byte clock
	output logic            line_clk_syn,      // Synthesized line clock
	output logic [3:0]      rec_clk,           // Recovered byte clocks
	output logic            frame_position_in  // Frame marker
);
	int unsigned lc_q = 0;
	int unsigned rc_q = 0;
	logic        armed_q = 1'b0;
	logic        bclk_q = 1'b0;
	logic        fpi_q = 1'b0;
	// ===================================================================
	// Clocks run free; recovered clock differs so loop timing shows
	always @(posedge mclk)
	begin
		lc_q <= (lc_q == 11) ? 0 : lc_q + 1;
		rc_q <= (rc_q == 79) ? 0 : rc_q + 1;
		bclk_q <= byte_clk;
		if (fp_go)
			armed_q <= 1'b1;
		// Marker held exactly one byte period, from rise to rise
		if (byte_clk && !bclk_q)
		begin
			fpi_q <= armed_q;
			armed_q <= 1'b0;
		end
	end
	assign line_clk_syn = (lc_q < 6);
	assign rec_clk = {4{rc_q < 40}};
	assign frame_position_in = fpi_q;
endmodule : line_side_partner
`default_nettype wire

/* File: verif/line_frame_timing_alarm_bench.sv */
// Self-checking testbench for the line frame timing and alarm block
`timescale 1ns/1ps
`default_nettype none
module line_frame_timing_alarm_bench;
	logic                               mclk = 1'b0;
	logic                               rst_n = 1'b0;
	line_timing_pkg::chan_alarm_t [3:0] alarm_in = '0;
	line_timing_pkg::chan_cfg_t [3:0]   chan_cfg = 12'h20D;
	logic       oe = 1'b0, fp_go = 1'b0, tss = 1'b0, synth = 1'b1;
	logic [1:0] psel = 2'h1;
	logic [3:0] ldat = 4'h0, rec_clk, ralm, tlc, tld, cbc, cfs;
	logic       line_clk, fpi, bclk, fpo;
	int         n_mismatch = 0, n_compared = 0, cyc = 0, n_bad, n_late;
	int         rc [9];
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		ldat <= ldat + 4'h1;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	line_frame_timing_alarm i_line_frame_timing_alarm (.mclk(mclk),
		.rst_n(rst_n), .alarm_in(alarm_in), .chan_cfg(chan_cfg),
		.line_clock_output_enable(oe), .line_clk_syn(line_clk),
		.line_data_in(ldat), .recovered_byte_clock(rec_clk),
		.frame_position_in(fpi), .timing_source_select(tss),
		.byte_clock_is_synth(synth), .pulse_channel_select(psel),
		.receive_alarm_out(ralm), .transmit_line_clock(tlc),
		.transmit_line_data(tld), .tx_byte_clock_out(bclk),
		.frame_pulse_out(fpo), .chan_byte_clock(cbc), .chan_frame_start(cfs));
	line_side_partner i_line_side_partner (.mclk(mclk), .fp_go(fp_go),
		.byte_clk(bclk), .line_clk_syn(line_clk), .rec_clk(rec_clk),
		.frame_position_in(fpi));
	// ===================================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// Counts rises over n cycles after a settling gap
	task automatic watch(input int n);
		logic [8:0] p, c;
		logic       d;
		rc = '{default: 0};
		n_bad = 0;
		n_late = 0;
		repeat (24) @(posedge mclk);
		#1 p = {fpo, bclk, tlc[1], cbc[1:0], cfs};
		d = tld[1];
		repeat (n)
		begin
			@(posedge mclk);
			#1 c = {fpo, bclk, tlc[1], cbc[1:0], cfs};
			for (int i = 0; i < 9; i++)
				rc[i] += int'(c[i] & !p[i]);
			n_late += int'(c[8] && !p[8] && !c[7]);
			n_bad += int'(tld[1] !== d && tlc[1]);
			p = c;
			d = tld[1];
		end
	endtask : watch
	task automatic pulse(input logic sel);
		@(posedge mclk);
		tss <= sel;
		fp_go <= 1'b1;
		@(posedge mclk);
		fp_go <= 1'b0;
		watch(480);
	endtask : pulse
	task automatic summarize();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// ===================================================================
	// Scenarios
	task automatic t_alarm();
		for (int s = 0; s < 14; s++)
		begin
			@(posedge mclk);
			for (int c = 0; c < 4; c++)
				alarm_in[c] <= {14'h0001 << s, (c % 2) ? ~(14'h0001 << s)
					: (14'h0001 << s)};
			repeat (3) @(posedge mclk);
			#1 chk("alarm out", 32'h5, ralm);
		end
	endtask : t_alarm
	task automatic t_clock();
		watch(960);
		chk("line clock gated", 0, rc[6]);
		@(posedge mclk);
		oe <= 1'b1;
		watch(960);
		chk("line clock rises", 80, rc[6]);
		chk("data on high clock", 0, n_bad);
		chk("byte clock rises", 10, rc[7]);
		chk("self byte clock", 10, rc[5]);
		chk("loop byte clock", 12, rc[4]);
	endtask : t_clock
	task automatic t_align();
		pulse(1'b0);
		chk("aligned start", 1, rc[1]);
		chk("loop start", 0, rc[0]);
		chk("unaligned start", 0, rc[2]);
		chk("aligned start ch3", 1, rc[3]);
		chk("frame pulse", 1, rc[8]);
		chk("pulse off edge", 0, n_late);
		watch(9600);
		chk("pulse spacing", 0, rc[8]);
		pulse(1'b1);
		chk("ignored start", 0, rc[1]);
		chk("ignored pulse", 0, rc[8]);
		@(posedge mclk);
		synth <= 1'b0;
		pulse(1'b0);
		chk("no synth start", 0, rc[1]);
		@(posedge mclk);
		synth <= 1'b1;
		psel <= 2'h0;
		pulse(1'b0);
		chk("loop pulse", 0, rc[8]);
		chk("loop sel start", 1, rc[1]);
	endtask : t_align
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_alarm();
		t_clock();
		t_align();
		summarize();
	end
endmodule : line_frame_timing_alarm_bench
`default_nettype wire
